// File: dv/sapo_pin_watch.sv
`timescale 1ns/10ps

module sapo_pin_watch (
    // pins from the device
    input wire logic ref_fail_out,
    input wire logic ref_fail_oe,
    input wire logic irq_los_out,
    input wire logic irq_los_oe,
    // levels seen on the board
    output logic ref_fail_wire,
    output logic irq_los_wire
);
    // no pull on this line, so a released pin reads opposite to what is offered
    assign ref_fail_wire = ref_fail_oe ? ref_fail_out : !ref_fail_out;
    // board pull-up makes the released open-drain line read high
    assign irq_los_wire = irq_los_oe ? irq_los_out : 1'h1;
endmodule // sapo_pin_watch

// File: dv/sapo_top_test.sv
`timescale 1ns/10ps

module sapo_top_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, src_switch_strap;
    logic [sapo_pkg::ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [sapo_pkg::DATA_W-1:0] hwdata, hrdata;
    sapo_pkg::sapo_mon_t mon;
    logic ref_fail_out, ref_fail_oe, lock_out, irq_los_out, irq_los_oe;
    logic external_fast_switch_mode, irq, ref_fail_wire, irq_los_wire;
    int bad_count, comparisons, seed;
    // reference model state
    int m_lock_en, m_cfg_ten, m_intcfg, m_status, m_mask, m_mon;

    sapo_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .mon(mon), .src_switch_strap(src_switch_strap), .ref_fail_out(ref_fail_out),
        .ref_fail_oe(ref_fail_oe), .lock_out(lock_out), .irq_los_out(irq_los_out),
        .irq_los_oe(irq_los_oe), .external_fast_switch_mode(external_fast_switch_mode),
        .irq(irq));

    sapo_pin_watch board (.ref_fail_out(ref_fail_out),
        .ref_fail_oe(ref_fail_oe), .irq_los_out(irq_los_out), .irq_los_oe(irq_los_oe),
        .ref_fail_wire(ref_fail_wire), .irq_los_wire(irq_los_wire));

    always #5 hclk = ~hclk;

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp_bit(input string what, input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: read %h got %h expected %h", $time, a, got, exp);
        end
    endtask

    // no bound here: the watchdog is the only limit on a stalled bus
    task automatic wait_ready;
        while (hreadyout !== 1'h1) begin
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        wait_ready();
        q = hrdata;
        cmp_bit("bus response", hresp, 1'h0);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
        case (a)
            sapo_pkg::OFF_MODE_CFG_ONE: m_lock_en = d[0];
            sapo_pkg::OFF_MODE_CFG_TEN: m_cfg_ten = d[1:0];
            sapo_pkg::OFF_INT_CFG: m_intcfg = d[4:0];
            sapo_pkg::OFF_STATUS_TWO: m_status = m_status & ~d[2:0];
            sapo_pkg::OFF_INT_MASK: m_mask = d[2:0];
            default: ;
        endcase
    endtask

    task automatic reg_chk(input logic [7:0] a);
        logic [31:0] q, e;
        bus(a, 1'h0, 32'h0, q);
        case (a)
            sapo_pkg::OFF_MODE_CFG_ONE: e = m_lock_en;
            sapo_pkg::OFF_MODE_CFG_TEN: e = m_cfg_ten;
            sapo_pkg::OFF_INT_CFG: e = m_intcfg;
            sapo_pkg::OFF_STATUS_TWO: e = m_status;
            sapo_pkg::OFF_INT_MASK: e = m_mask;
            sapo_pkg::OFF_LIVE: e = {((m_status & m_mask) != 0), m_mon[2:0]};
            default: e = 32'h0;
        endcase
        cmp_word(a, q, e);
    endtask

    task automatic settle;
        repeat (5) @(posedge hclk);
        #1;
        if (!(m_mon[0] && m_mon[1])) begin
            m_status = m_status | 1;
        end
    endtask

    task automatic chk_pins;
        logic any, lvl;
        any = (m_status & m_mask) != 0;
        lvl = m_intcfg[3] ? m_intcfg[4] : (any == m_intcfg[1]);
        if (m_intcfg[0]) begin
            lvl = !m_mon[0];
        end
        cmp_bit("ref fail enable", ref_fail_oe, m_cfg_ten[0]);
        if (m_cfg_ten[0]) begin
            cmp_bit("ref fail pin", ref_fail_wire, m_status[0]);
        end
        cmp_bit("lock pin", lock_out, m_lock_en[0] & m_mon[2]);
        cmp_bit("shared pin", irq_los_wire, lvl);
        cmp_bit("shared enable", irq_los_oe, (m_intcfg[2] && !m_intcfg[0]) ? !lvl : 1'h1);
        cmp_bit("irq", irq, any);
        cmp_bit("fast switch", external_fast_switch_mode, m_cfg_ten[1]);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge hclk);
        hresetn <= 1'h0;
        src_switch_strap <= strap;
        m_lock_en = 0;
        m_cfg_ten = 0;
        m_intcfg = 0;
        m_mask = 0;
        m_status = 0;
        repeat (10) @(posedge hclk);
        #1;
        chk_pins();
        @(posedge hclk);
        hresetn <= 1'h1;
        // monitors restart from zero, so the sync stage sees a failure, and a lock rise when the lock input is high
        m_cfg_ten = {strap, 1'h0};
        m_status = 1 | (m_mon[2] ? 4 : 0);
        settle();
        chk_pins();
    endtask

    task automatic run_batch(input int n);
        logic [31:0] w, r;
        for (int i = 0; i < n; i++) begin
            r = $random(seed);
            @(posedge hclk);
            mon <= r[2:0];
            if (m_mon[2] != r[2]) begin
                m_status = m_status | (r[2] ? 4 : 2);
            end
            m_mon = r[2:0];
            reg_wr(sapo_pkg::OFF_MODE_CFG_ONE, $random(seed));
            reg_wr(sapo_pkg::OFF_MODE_CFG_TEN, $random(seed));
            w = $random(seed);
            // loss mode only alongside external fast switching
            w[0] = w[0] & m_cfg_ten[1];
            reg_wr(sapo_pkg::OFF_INT_CFG, w);
            reg_wr(sapo_pkg::OFF_INT_MASK, $random(seed));
            settle();
            chk_pins();
            for (int k = 0; k < 7; k++) begin
                reg_chk(8'(k * 4));
            end
            reg_wr(sapo_pkg::OFF_STATUS_TWO, r[10:3]);
            settle();
            chk_pins();
            reg_chk(sapo_pkg::OFF_STATUS_TWO);
        end
    endtask

    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mon = 3'h3;
        m_mon = 3;
        src_switch_strap = 1'h0;
        bad_count = 0;
        comparisons = 0;
        seed = 32'h24dfc8c4;
        do_reset(1'h0);
        run_batch(40);
        reg_wr(8'h18, 32'hffffffff);
        reg_wr(sapo_pkg::OFF_LIVE, 32'hffffffff);
        reg_chk(8'h18);
        reg_chk(sapo_pkg::OFF_LIVE);
        do_reset(1'h1);
        run_batch(20);
        wrap_up();
    end

    initial begin
        #400000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule // sapo_top_test

// File: rtl/sapo_top.sv
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

module sapo_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [sapo_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [sapo_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [sapo_pkg::DATA_W-1:0] hrdata,
    // reference and dpll monitors
    input wire sapo_pkg::sapo_mon_t mon,
    input wire logic src_switch_strap,
    // status pins
    output logic ref_fail_out,
    output logic ref_fail_oe,
    output logic lock_out,
    output logic irq_los_out,
    output logic irq_los_oe,
    // system side
    output logic external_fast_switch_mode,
    output logic irq
);

    // synchronisers: stage one is read only by stage two
    logic [sapo_pkg::MON_W:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic act_s, freq_s, lock_s, strap_s;
    logic lock_prev_q, lock_prev_d;
    logic [1:0] strap_cnt_q, strap_cnt_d;

    assign act_s = sync2_q[0];
    assign freq_s = sync2_q[1];
    assign lock_s = sync2_q[2];
    assign strap_s = sync2_q[3];

    always_comb begin
        sync1_d = {src_switch_strap, mon};
        sync2_d = sync1_q;
        lock_prev_d = lock_s;
        strap_cnt_d = strap_cnt_q;
        if (strap_cnt_q != sapo_pkg::STRAP_DONE) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            lock_prev_q <= 1'h0;
            strap_cnt_q <= 2'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            lock_prev_q <= lock_prev_d;
            strap_cnt_q <= strap_cnt_d;
        end
    end

    // bus address phase capture
    logic wr_q, wr_d;
    logic [sapo_pkg::ADDR_W-1:0] waddr_q, waddr_d;
    logic [sapo_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic access;

    // register state
    logic lock_en_q, lock_en_d;
    logic ref_fail_pin_enable_q, ref_fail_pin_enable_d;
    logic ext_switch_q, ext_switch_d;
    sapo_pkg::sapo_intcfg_t intcfg_q, intcfg_d;
    sapo_pkg::sapo_event_t status_q, status_d, mask_q, mask_d, event_now, w1c;
    logic irq_any;
    logic ref_fail_flag;

    assign access = hsel && hready && htrans[sapo_pkg::HTRANS_ACTIVE_BIT];
    assign ref_fail_flag = status_q.ref_fail;
    assign irq_any = |(status_q & mask_q);

    // read returns next values so a read right after a write sees the write
    function automatic logic [sapo_pkg::DATA_W-1:0] read_mux(
        input logic [sapo_pkg::ADDR_W-1:0] a
    );
        logic [sapo_pkg::DATA_W-1:0] r;
        r = '0;
        unique case (a)
            sapo_pkg::OFF_MODE_CFG_ONE: r[sapo_pkg::LOCK_EN_BIT] = lock_en_d;
            sapo_pkg::OFF_MODE_CFG_TEN: begin
                r[sapo_pkg::REF_FAIL_PIN_EN_BIT] = ref_fail_pin_enable_d;
                r[sapo_pkg::EXT_SWITCH_BIT] = ext_switch_d;
            end
            sapo_pkg::OFF_INT_CFG: r[sapo_pkg::INT_CFG_W-1:0] = intcfg_d;
            sapo_pkg::OFF_STATUS_TWO: r[sapo_pkg::EVENT_W-1:0] = status_d;
            sapo_pkg::OFF_INT_MASK: r[sapo_pkg::EVENT_W-1:0] = mask_d;
            sapo_pkg::OFF_LIVE: r[sapo_pkg::MON_W:0] = {irq_any, lock_s, freq_s, act_s};
            default: r = '0;
        endcase
        return r;
    endfunction

    always_comb begin
        wr_d = access && hwrite;
        waddr_d = access ? haddr : waddr_q;
        rdata_d = rdata_q;
        if (access && !hwrite) begin
            rdata_d = read_mux(haddr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'h0;
            waddr_q <= '0;
            rdata_q <= '0;
        end else begin
            wr_q <= wr_d;
            waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    // zero wait states, always okay; unmapped reads return zero
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = rdata_q;

    always_comb begin
        event_now.ref_fail = !act_s || !freq_s;
        event_now.lock_lost = lock_prev_q && !lock_s;
        event_now.lock_gained = !lock_prev_q && lock_s;
        w1c = '0;
        lock_en_d = lock_en_q;
        ref_fail_pin_enable_d = ref_fail_pin_enable_q;
        ext_switch_d = ext_switch_q;
        intcfg_d = intcfg_q;
        mask_d = mask_q;
        if (wr_q) begin
            unique case (waddr_q)
                sapo_pkg::OFF_MODE_CFG_ONE: lock_en_d = hwdata[sapo_pkg::LOCK_EN_BIT];
                sapo_pkg::OFF_MODE_CFG_TEN: begin
                    ref_fail_pin_enable_d = hwdata[sapo_pkg::REF_FAIL_PIN_EN_BIT];
                    ext_switch_d = hwdata[sapo_pkg::EXT_SWITCH_BIT];
                end
                sapo_pkg::OFF_INT_CFG: intcfg_d = hwdata[sapo_pkg::INT_CFG_W-1:0];
                sapo_pkg::OFF_STATUS_TWO: w1c = hwdata[sapo_pkg::EVENT_W-1:0];
                sapo_pkg::OFF_INT_MASK: mask_d = hwdata[sapo_pkg::EVENT_W-1:0];
                default: w1c = '0;
            endcase
        end
        // strap wins over an early software write, it only happens once
        if (strap_cnt_q == sapo_pkg::STRAP_WAIT) begin
            ext_switch_d = strap_s;
        end
        // a new event beats a clear in the same cycle
        status_d = (status_q & ~w1c) | event_now;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_en_q <= sapo_pkg::LOCK_EN_RST;
            ref_fail_pin_enable_q <= sapo_pkg::REF_FAIL_PIN_EN_RST;
            ext_switch_q <= sapo_pkg::EXT_SWITCH_RST;
            intcfg_q <= sapo_pkg::INT_CFG_RST;
            status_q <= sapo_pkg::STATUS_RST;
            mask_q <= sapo_pkg::MASK_RST;
        end else begin
            lock_en_q <= lock_en_d;
            ref_fail_pin_enable_q <= ref_fail_pin_enable_d;
            ext_switch_q <= ext_switch_d;
            intcfg_q <= intcfg_d;
            status_q <= status_d;
            mask_q <= mask_d;
        end
    end

    // pin drivers
    logic ref_fail_out_q, ref_fail_out_d, ref_fail_oe_q, ref_fail_oe_d;
    logic lock_out_q, lock_out_d;
    logic shared_out_q, shared_out_d, shared_oe_q, shared_oe_d;
    logic ext_sw_out_q, ext_sw_out_d, irq_q, irq_d;
    logic shared_level;

    always_comb begin
        ref_fail_oe_d = ref_fail_pin_enable_q;
        ref_fail_out_d = ref_fail_pin_enable_q && ref_fail_flag;
        lock_out_d = lock_en_q && lock_s;
        ext_sw_out_d = ext_switch_q;
        irq_d = irq_any;
        shared_out_d = 1'h0;
        shared_oe_d = 1'h1;
        if (intcfg_q.gpo_en) begin
            shared_level = intcfg_q.gpo_level;
        end else begin
            shared_level = (irq_any == intcfg_q.active_high);
        end
        if (intcfg_q.los_mode) begin
            // loss is the unlatched inverse of activity, always push-pull
            shared_out_d = !act_s;
        end else if (intcfg_q.open_drain) begin
            shared_oe_d = !shared_level;
        end else begin
            shared_out_d = shared_level;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_fail_out_q <= 1'h0;
            ref_fail_oe_q <= 1'h0;
            lock_out_q <= 1'h0;
            shared_out_q <= sapo_pkg::SHARED_OUT_RST;
            shared_oe_q <= sapo_pkg::SHARED_OE_RST;
            ext_sw_out_q <= sapo_pkg::EXT_SWITCH_RST;
            irq_q <= 1'h0;
        end else begin
            ref_fail_out_q <= ref_fail_out_d;
            ref_fail_oe_q <= ref_fail_oe_d;
            lock_out_q <= lock_out_d;
            shared_out_q <= shared_out_d;
            shared_oe_q <= shared_oe_d;
            ext_sw_out_q <= ext_sw_out_d;
            irq_q <= irq_d;
        end
    end

    assign ref_fail_out = ref_fail_out_q;
    assign ref_fail_oe = ref_fail_oe_q;
    assign lock_out = lock_out_q;
    assign irq_los_out = shared_out_q;
    assign irq_los_oe = shared_oe_q;
    assign external_fast_switch_mode = ext_sw_out_q;
    assign irq = irq_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ref_fail_mirror;
        ref_fail_pin_enable_q |=> ref_fail_oe && (ref_fail_out == $past(ref_fail_flag));
    endproperty
    a_ref_fail_mirror: assert property (p_ref_fail_mirror)
        else $error("ref fail pin does not mirror flag");

    property p_ref_fail_hiz;
        !ref_fail_pin_enable_q |=> !ref_fail_oe;
    endproperty
    a_ref_fail_hiz: assert property (p_ref_fail_hiz)
        else $error("ref fail pin driven while disabled");

    property p_lock_follow;
        lock_en_q |=> lock_out == $past(lock_s);
    endproperty
    a_lock_follow: assert property (p_lock_follow)
        else $error("lock pin does not follow dpll lock");

    property p_lock_low;
        !lock_en_q |=> !lock_out;
    endproperty
    a_lock_low: assert property (p_lock_low)
        else $error("lock pin not low while disabled");

    property p_mode_write;
        (wr_q && waddr_q == sapo_pkg::OFF_INT_CFG && hwdata[0])
            |=> intcfg_q.los_mode ##1 (irq_los_oe && irq_los_out == !$past(act_s));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("loss mode select not effective");

    property p_irq_polarity;
        (!intcfg_q.los_mode && !intcfg_q.gpo_en && !intcfg_q.open_drain)
            |=> irq_los_oe && (irq_los_out == ($past(irq_any) == $past(intcfg_q.active_high)));
    endproperty
    a_irq_polarity: assert property (p_irq_polarity)
        else $error("interrupt pin polarity wrong");

    property p_open_drain;
        (!intcfg_q.los_mode && !intcfg_q.gpo_en && intcfg_q.open_drain)
            |=> !irq_los_out && (irq_los_oe == ($past(irq_any) != $past(intcfg_q.active_high)));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain drive wrong");

    property p_gpo;
        (!intcfg_q.los_mode && intcfg_q.gpo_en && !intcfg_q.open_drain)
            |=> irq_los_oe && irq_los_out == $past(intcfg_q.gpo_level);
    endproperty
    a_gpo: assert property (p_gpo)
        else $error("general purpose output level wrong");

    property p_los;
        intcfg_q.los_mode |=> irq_los_oe && irq_los_out == !$past(act_s);
    endproperty
    a_los: assert property (p_los)
        else $error("loss pin does not track activity");

    // reset can lift on an edge whose flops still took the reset branch
    property p_fail_sets;
        hresetn && (!act_s || !freq_s) |=> ref_fail_flag;
    endproperty
    a_fail_sets: assert property (p_fail_sets)
        else $error("reference fail flag not set");

    property p_irq_out;
        (ref_fail_flag && mask_q.ref_fail) |=> irq ##0 $past(irq_any);
    endproperty
    a_irq_out: assert property (p_irq_out)
        else $error("interrupt output not raised");

    property p_fail_clears;
        (wr_q && waddr_q == sapo_pkg::OFF_STATUS_TWO && hwdata[0] && act_s && freq_s)
            |=> !ref_fail_flag;
    endproperty
    a_fail_clears: assert property (p_fail_clears)
        else $error("reference fail flag not cleared");

    // checked while reset is held, so this one is never disabled
    property p_reset_pins;
        disable iff (1'h0)
        !hresetn ##1 !hresetn |-> !ref_fail_oe && !lock_out && irq_los_oe && irq_los_out
            && !irq && !external_fast_switch_mode;
    endproperty
    a_reset_pins: assert property (p_reset_pins)
        else $error("pins not at defaults during reset");

    c_los_loss: cover property (intcfg_q.los_mode && !act_s ##1 irq_los_out);
    c_ref_fail_pin: cover property (ref_fail_oe && ref_fail_out);
    c_od_low: cover property (intcfg_q.open_drain && irq_los_oe && !intcfg_q.los_mode);
    c_w1c: cover property (wr_q && waddr_q == sapo_pkg::OFF_STATUS_TWO ##1 !ref_fail_flag);

endmodule // sapo_top

// File: shared/sapo_pkg.sv
package sapo_pkg;

    // bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // register byte offsets
    localparam logic [7:0] OFF_MODE_CFG_ONE = 8'h00;
    localparam logic [7:0] OFF_MODE_CFG_TEN = 8'h04;
    localparam logic [7:0] OFF_INT_CFG = 8'h08;
    localparam logic [7:0] OFF_STATUS_TWO = 8'h0c;
    localparam logic [7:0] OFF_INT_MASK = 8'h10;
    localparam logic [7:0] OFF_LIVE = 8'h14;

    // field positions
    localparam int LOCK_EN_BIT = 0;
    localparam int REF_FAIL_PIN_EN_BIT = 0;
    localparam int EXT_SWITCH_BIT = 1;
    localparam int INT_CFG_W = 5;
    localparam int EVENT_W = 3;
    localparam int MON_W = 3;

    // reset values
    localparam logic LOCK_EN_RST = 1'h0;
    localparam logic REF_FAIL_PIN_EN_RST = 1'h0;
    localparam logic EXT_SWITCH_RST = 1'h0;
    localparam logic [INT_CFG_W-1:0] INT_CFG_RST = 5'h00;
    localparam logic [EVENT_W-1:0] STATUS_RST = 3'h0;
    localparam logic [EVENT_W-1:0] MASK_RST = 3'h0;
    localparam logic SHARED_OUT_RST = 1'h1;
    localparam logic SHARED_OE_RST = 1'h1;

    // strap sampling: cycles after release before the synchronised strap is valid
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // interrupt configuration fields, los_mode in bit 0
    typedef struct packed {
        logic gpo_level;
        logic gpo_en;
        logic open_drain;
        logic active_high;
        logic los_mode;
    } sapo_intcfg_t;

    // sticky events, ref_fail in bit 0
    typedef struct packed {
        logic lock_gained;
        logic lock_lost;
        logic ref_fail;
    } sapo_event_t;

    // live monitor inputs of the selected reference and the main dpll
    typedef struct packed {
        logic dpll_locked;
        logic freq_ok;
        logic act_ok;
    } sapo_mon_t;

endpackage
